/* rtl/brtc_consts.svh */
// Functional notes
// RL1 - Write cycle exists while strobe low, low select low, high select high together.
// RL2 - Write cycle starts at the last of the three qualifying edges.
// RL3 - Write cycle ends at the first releasing edge; data captured then.
// RL4 - Host holds address stable through the write and releases before changing it.
// RL5 - Host keeps output gate high during writes to avoid bus contention.
// RL6 - Asserting the write strobe floats data outputs even if a read was driving.
// RL7 - In power-fail window device deselects, blocks writes, floats outputs, ignores inputs.
// RL8 - Power loss during a write may corrupt only the addressed byte.
// RL9 - Writes stay blocked for a recovery delay after supply passes the threshold.
// RL10 - Host holds device deselected while supply rises through the threshold.
// RL11 - Interrupt asserts at trip point; deselect follows after 10 to 40 us.
// RL12 - Interrupt pin is open drain: pulls low only, never drives high.
// RL13 - Freeze bit (control bit 6) stops copying counters into clock bytes.
// RL14 - Frozen clock bytes hold the time at freeze; counters keep running.
// RL15 - All clock bytes update at once; freeze waits; updates resume within a second. The code drops a refresh still pending when freeze takes effect.
// RL16 - Load bit also halts updates; clearing it loads time bytes into counters.
// RL17 - Software writes zero to frequency test bit and must-be-zero bits.
// RL18 - Calendar bytes BCD: year, month, date, weekday with frequency test bit 6.
// RL19 - Time bytes 24-hour BCD; seconds byte bit 7 is oscillator halt.
// RL20 - Control byte: load bit 7, freeze bit 6, sign bit 5, magnitude 4..0.
// RL21 - Writing one to halt bit stops oscillator; clearing restarts within a second.
// RL22 - Software sets then clears halt bit after first power-up.
// RL23 - Strobe high with both selects active is a read cycle.
// RL24 - Clock bytes refresh each second unless freeze or load is set.
// RL25 - Calibration magnitude 0 to 31; sign one means positive correction. The code stores these control bits but applies no correction.
// RL26 - With frequency test set and oscillator running, seconds bit 0 toggles at 512 Hz.
// RL27 - Counters advance on a binary-divided one-second tick, halted while oscillator stops.
`ifndef BRTC_CONSTS_SVH
`define BRTC_CONSTS_SVH

`define BRTC_ADDR_W        13
`define BRTC_CTRL_ADDR     13'h1FF8
`define BRTC_SEC_ADDR      13'h1FF9
`define BRTC_MIN_ADDR      13'h1FFA
`define BRTC_HOUR_ADDR     13'h1FFB
`define BRTC_WDAY_ADDR     13'h1FFC
`define BRTC_DATE_ADDR     13'h1FFD
`define BRTC_MON_ADDR      13'h1FFE
`define BRTC_YEAR_ADDR     13'h1FFF
`define BRTC_LOAD_BIT      7
`define BRTC_FREEZE_BIT    6
`define BRTC_SIGN_BIT      5
`define BRTC_HALT_BIT      7
`define BRTC_PROBE_BIT     6
`define BRTC_OSC_HZ        32768
`define BRTC_PROBE_HZ      512
`define BRTC_CLK_MHZ       40
`define BRTC_DESEL_MIN_US  10
`define BRTC_DESEL_MAX_US  40
`define BRTC_REC_US        1000
`define BRTC_CTRL_RST      8'h00
`define BRTC_SEC_RST       8'h80

`endif

/* rtl/brtc_pkg.sv */
package brtc_pkg;
  // Parallel bus pins as seen by the device
  typedef struct packed {
    logic [12:0] addr;
    logic [7:0]  wdata;
    logic        select_low_active_n;
    logic        select_high_active;
    logic        gate_n;
    logic        strobe_n;
  } brtc_bus_t;

  // Calendar counters, all BCD
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] wday;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } brtc_time_t;

  typedef enum logic [1:0] {PWR_OK, PWR_WARN, PWR_OFF, PWR_REC} brtc_pwr_t;
endpackage

/* rtl/brtc_sram.sv */
`timescale 1ns/100ps
`default_nettype none
// Byte-wide storage, registered read data
module brtc_sram #(
  parameter int AW = 13
) (
  input  wire logic          clock,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  // Only the addressed word is written, so a lost write touches one byte
  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;  // [RL8]
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

/* rtl/brtc_count.sv */
`timescale 1ns/100ps
`default_nettype none
`include "brtc_consts.svh"
// Calendar counters advanced by a one-second tick
module brtc_count
  import brtc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       tick,
  input  wire logic       load,
  input  wire brtc_time_t load_val,
  output brtc_pkg::brtc_time_t now
);
  import brtc_pkg::*;
  brtc_time_t now_reg, now_next;

  // BCD increment with wrap to a floor value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
                                         input logic [7:0] floor);
    if (v >= top) bcd_inc = floor;
    else if (v[3:0] == 4'h9) bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Days in the month, leap years every fourth year
  function automatic logic [7:0] mdays(input logic [7:0] m, input logic [7:0] y);
    logic [7:0] bin;
    bin = 8'(y[7:4] * 4'hA) + {4'h0, y[3:0]};
    unique case (m)
      8'h02:                      mdays = (bin[1:0] == 2'b00) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: mdays = 8'h30;
      default:                    mdays = 8'h31;
    endcase
  endfunction

  // Ripple carry through the calendar on each tick
  always_comb begin
    now_next = now_reg;
    if (load) begin
      now_next = load_val;  // [RL16]
    end else if (tick) begin
      now_next.sec = bcd_inc(now_reg.sec, 8'h59, 8'h00);  // [RL27]
      if (now_reg.sec == 8'h59) begin
        now_next.min = bcd_inc(now_reg.min, 8'h59, 8'h00);
        if (now_reg.min == 8'h59) begin
          now_next.hour = bcd_inc(now_reg.hour, 8'h23, 8'h00);  // [RL19]
          if (now_reg.hour == 8'h23) begin
            now_next.wday = bcd_inc(now_reg.wday, 8'h07, 8'h01);  // [RL18]
            now_next.date = bcd_inc(now_reg.date, mdays(now_reg.month, now_reg.year), 8'h01);
            if (now_reg.date >= mdays(now_reg.month, now_reg.year)) begin
              now_next.month = bcd_inc(now_reg.month, 8'h12, 8'h01);
              if (now_reg.month == 8'h12) begin
                now_next.year = bcd_inc(now_reg.year, 8'h99, 8'h00);
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) now_reg <= '0;
    else now_reg <= now_next;
  end

  assign now = now_reg;
endmodule
`default_nettype wire

/* rtl/brtc_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "brtc_consts.svh"
// Byte-wide memory with calendar clock bytes at the top addresses
module brtc_top
  import brtc_pkg::*;
#(
  parameter int OSC_HZ      = `BRTC_OSC_HZ,
  parameter int DESEL_US    = `BRTC_DESEL_MIN_US,
  parameter int REC_CYCLES  = `BRTC_REC_US * `BRTC_CLK_MHZ
) (
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic                osc_tick,
  input  wire logic                power_fail,
  input  wire brtc_pkg::brtc_bus_t bus,
  output logic               [7:0] dq_out,
  output logic                     dq_oe_n,
  output logic                     int_out,
  output logic                     int_oe_n,
  output logic                     deselected
);
  import brtc_pkg::*;

  localparam int DESEL_CYC = DESEL_US * `BRTC_CLK_MHZ;
  localparam int DIV_W     = $clog2(OSC_HZ);
  // Probe is timed off the raw oscillator pulse, so a shortened second leaves it at 512 Hz
  localparam int PROBE_DIV = `BRTC_OSC_HZ / (2 * `BRTC_PROBE_HZ);

  // Power state, timed by the system clock
  brtc_pwr_t   pwr_reg, pwr_next;
  logic [31:0] ptmr_reg, ptmr_next;
  logic        wr_reg, wr_next;
  logic [12:0] wa_reg, wa_next;
  logic [7:0]  wd_reg, wd_next;
  logic [7:0]  ctrl_reg, ctrl_next;
  logic [7:0]  cb_reg [0:6];
  logic [7:0]  cb_next [0:6];
  logic [DIV_W-1:0] div_reg, div_next;
  logic        sec_tick, load_pulse, upd_pend_reg, upd_pend_next;
  logic        probe_reg, probe_next;
  logic [15:0] pdiv_reg, pdiv_next;
  logic [7:0]  dq_next, ram_q;
  logic        oe_n_next, int_n_next, desel_next;
  logic        cyc_wr, cyc_rd, blocked, wr_end, ram_we;
  brtc_time_t  now, load_val;

  function automatic logic is_clk(input logic [12:0] a);
    is_clk = (a >= `BRTC_CTRL_ADDR);
  endfunction

  // Cycle decode: inputs ignored while blocked
  always_comb begin
    blocked = (pwr_reg == PWR_OFF) || (pwr_reg == PWR_REC);  // [RL7] [RL9]
    cyc_wr  = !blocked && !bus.strobe_n && !bus.select_low_active_n
              && bus.select_high_active;  // [RL1] [RL2]
    cyc_rd  = !blocked && bus.strobe_n && !bus.select_low_active_n
              && bus.select_high_active;  // [RL23]
    wr_end  = wr_reg && !cyc_wr;  // [RL3]
  end

  // Power sequencing: warn, deselect after delay, recover
  always_comb begin
    pwr_next  = pwr_reg;
    ptmr_next = ptmr_reg;
    unique case (pwr_reg)
      PWR_OK: if (power_fail) begin
        pwr_next  = PWR_WARN;  // [RL11]
        ptmr_next = '0;
      end
      PWR_WARN: begin
        ptmr_next = ptmr_reg + 32'h1;
        if (ptmr_reg >= 32'(DESEL_CYC - 1)) pwr_next = PWR_OFF;  // [RL11]
      end
      PWR_OFF: if (!power_fail) begin
        pwr_next  = PWR_REC;
        ptmr_next = '0;
      end
      PWR_REC: begin
        ptmr_next = ptmr_reg + 32'h1;
        if (power_fail) pwr_next = PWR_OFF;
        else if (ptmr_reg >= 32'(REC_CYCLES - 1)) pwr_next = PWR_OK;  // [RL9]
      end
    endcase
  end

  // Write capture: latch address and data while active, commit on release
  always_comb begin
    wr_next = cyc_wr;
    wa_next = cyc_wr ? bus.addr  : wa_reg;
    wd_next = cyc_wr ? bus.wdata : wd_reg;
    // Losing power mid-write aborts it; only that byte is uncertain
    ram_we  = wr_end && (pwr_next != PWR_OFF) && !blocked;  // [RL3] [RL8]
  end

  // Oscillator divider down to one second, halted by the halt bit
  always_comb begin
    div_next  = div_reg;
    sec_tick  = 1'b0;
    pdiv_next = pdiv_reg;
    probe_next = probe_reg;
    if (osc_tick && !cb_reg[0][`BRTC_HALT_BIT]) begin  // [RL21]
      div_next = div_reg + 1'b1;
      sec_tick = (div_reg == DIV_W'(OSC_HZ - 1));  // [RL27]
      if (div_reg == DIV_W'(OSC_HZ - 1)) div_next = '0;
      pdiv_next = pdiv_reg + 16'h1;
      if (pdiv_reg >= 16'(PROBE_DIV - 1)) begin
        pdiv_next  = '0;
        probe_next = !probe_reg;  // [RL26]
      end
    end
  end

  // Clearing the load bit pushes the time bytes into the counters
  always_comb begin
    load_pulse = ram_we && (wa_reg == `BRTC_CTRL_ADDR) && ctrl_reg[`BRTC_LOAD_BIT]
                 && !wd_reg[`BRTC_LOAD_BIT];  // [RL16]
    load_val = '{year: cb_reg[6], month: cb_reg[5], date: cb_reg[4], wday: cb_reg[3],
                 hour: cb_reg[2], min: {1'b0, cb_reg[1][6:0]}, sec: {1'b0, cb_reg[0][6:0]}};
  end

  brtc_count u_count (
    .clock    (clock),
    .rstn     (rstn),
    .tick     (sec_tick),
    .load     (load_pulse),
    .load_val (load_val),
    .now      (now)
  );

  brtc_sram #(.AW(`BRTC_ADDR_W)) u_sram (
    .clock (clock),
    .we    (ram_we && !is_clk(wa_reg)),
    .waddr (wa_reg),
    .wdata (wd_reg),
    .raddr (bus.addr),
    .rdata (ram_q)
  );

  // Clock bytes: host writes, and a single-step refresh each second
  always_comb begin
    logic halt_upd;
    halt_upd = ctrl_reg[`BRTC_LOAD_BIT] || ctrl_reg[`BRTC_FREEZE_BIT];  // [RL13] [RL16]
    ctrl_next = ctrl_reg;
    for (int i = 0; i < 7; i++) cb_next[i] = cb_reg[i];
    // A refresh pending when freeze or load takes effect is dropped unless a new tick lands in that same cycle
    upd_pend_next = sec_tick;
    if (upd_pend_reg && (!halt_upd || sec_tick)) begin  // [RL15] [RL24]
      cb_next[0] = {cb_reg[0][7], now.sec[6:0]};  // [RL14]
      cb_next[1] = now.min;
      cb_next[2] = now.hour;
      cb_next[3] = {cb_reg[3][7:6], now.wday[5:0]};
      cb_next[4] = now.date;
      cb_next[5] = now.month;
      cb_next[6] = now.year;
    end
    if (cb_reg[3][`BRTC_PROBE_BIT] && !cb_reg[0][`BRTC_HALT_BIT]) begin
      cb_next[0][0] = probe_reg;  // [RL26]
    end
    if (ram_we && is_clk(wa_reg)) begin
      if (wa_reg == `BRTC_CTRL_ADDR) ctrl_next = wd_reg;  // [RL20] [RL25]
      else cb_next[3'(wa_reg - `BRTC_SEC_ADDR)] = wd_reg;  // [RL19] [RL21]
    end
  end

  // Pins: data floats on writes, blocking, or gate high
  always_comb begin
    oe_n_next  = !(cyc_rd && !bus.gate_n);  // [RL6] [RL7]
    dq_next    = is_clk(bus.addr)
                 ? ((bus.addr == `BRTC_CTRL_ADDR) ? ctrl_reg
                    : cb_reg[3'(bus.addr - `BRTC_SEC_ADDR)])
                 : ram_q;
    int_n_next = !(pwr_next != PWR_OK && pwr_next != PWR_REC);  // [RL11]
    desel_next = (pwr_next == PWR_OFF) || (pwr_next == PWR_REC);
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pwr_reg      <= PWR_OK;
      ptmr_reg     <= '0;
      wr_reg       <= 1'b0;
      wa_reg       <= '0;
      wd_reg       <= '0;
      ctrl_reg     <= `BRTC_CTRL_RST;
      for (int i = 0; i < 7; i++) cb_reg[i] <= 8'h00;
      div_reg      <= '0;
      pdiv_reg     <= '0;
      probe_reg    <= 1'b0;
      upd_pend_reg <= 1'b0;
      dq_out       <= 8'h00;
      dq_oe_n      <= 1'b1;
      int_oe_n     <= 1'b1;
      deselected   <= 1'b0;
    end else begin
      pwr_reg      <= pwr_next;
      ptmr_reg     <= ptmr_next;
      wr_reg       <= wr_next;
      wa_reg       <= wa_next;
      wd_reg       <= wd_next;
      ctrl_reg     <= ctrl_next;
      for (int i = 0; i < 7; i++) cb_reg[i] <= cb_next[i];
      div_reg      <= div_next;
      pdiv_reg     <= pdiv_next;
      probe_reg    <= probe_next;
      upd_pend_reg <= upd_pend_next;
      dq_out       <= dq_next;
      dq_oe_n      <= oe_n_next;
      int_oe_n     <= int_n_next;  // [RL12]
      deselected   <= desel_next;
    end
  end

  // Open drain: only ever drives low
  always_ff @(posedge clock) begin
    int_out <= 1'b0;  // [RL12]
  end
endmodule
`default_nettype wire

/* verif/brtc_top_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// Checks on the bus outputs, the power-fail interrupt and the deselect timing
module brtc_top_properties #(
  parameter int OSC_HZ     = 64,
  parameter int DESEL_US   = 10,
  parameter int REC_CYCLES = 20
) (
  input wire logic                clock,
  input wire logic                rstn,
  input wire logic                osc_tick,
  input wire logic                power_fail,
  input wire brtc_pkg::brtc_bus_t bus,
  input wire logic          [7:0] dq_out,
  input wire logic                dq_oe_n,
  input wire logic                int_out,
  input wire logic                int_oe_n,
  input wire logic                deselected
);
  import brtc_pkg::*;
  localparam int DMIN = 10 * 40 - 3;
  localparam int DMAX = 40 * 40 + 3;
  logic [15:0] fail_cnt;
  logic [15:0] fail_cnt_next;
  logic [15:0] rec_cnt;
  logic [15:0] rec_cnt_next;
  logic        wr_cyc;
  logic        rd_cyc;

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  // Cycles since the trip point, and cycles of recovery; they bound the waits
  always_comb begin
    wr_cyc = !bus.strobe_n && !bus.select_low_active_n && bus.select_high_active;
    rd_cyc = bus.strobe_n && !bus.select_low_active_n && bus.select_high_active && !bus.gate_n;
    fail_cnt_next = !power_fail ? 16'h0000 : (deselected ? fail_cnt : fail_cnt + 16'h0001);
    rec_cnt_next = (power_fail || !deselected) ? 16'h0000 : rec_cnt + 16'h0001;
  end

  always_ff @(posedge clock) begin
    fail_cnt <= rstn ? fail_cnt_next : 16'h0000;
    rec_cnt  <= rstn ? rec_cnt_next : 16'h0000;
  end

  a_int_low_only: assert property (!int_out) else $error("interrupt pin driven high");
  a_int_at_trip: assert property ($rose(power_fail) && !deselected |-> ##[1:2] !int_oe_n)
    else $error("interrupt late after trip");
  a_desel_delay: assert property ($rose(deselected) |-> fail_cnt >= DMIN && fail_cnt <= DMAX)
    else $error("deselect outside its delay window");
  a_desel_float: assert property (deselected |=> dq_oe_n) else $error("drive while deselected");
  a_write_float: assert property (wr_cyc |=> dq_oe_n) else $error("drive during write");
  a_read_drives: assert property (rd_cyc && !power_fail && !deselected |=> !dq_oe_n)
    else $error("read not driven");
  a_unsel_float: assert property (!wr_cyc && !rd_cyc |=> dq_oe_n)
    else $error("drive without read");
  a_rec_delay: assert property ($fell(deselected) |->
    rec_cnt >= REC_CYCLES - 2 && rec_cnt <= REC_CYCLES + 2) else $error("recovery length wrong");
  a_rec_bound: assert property (rec_cnt <= REC_CYCLES + 2) else $error("recovery too long");
  a_int_release: assert property ($rose(int_oe_n) |-> deselected && !$past(power_fail))
    else $error("interrupt released early");
endmodule

bind brtc_top brtc_top_properties #(
  .OSC_HZ    (OSC_HZ),
  .DESEL_US  (DESEL_US),
  .REC_CYCLES(REC_CYCLES)
) i_brtc_top_properties (
  .clock     (clock),
  .rstn      (rstn),
  .osc_tick  (osc_tick),
  .power_fail(power_fail),
  .bus       (bus),
  .dq_out    (dq_out),
  .dq_oe_n   (dq_oe_n),
  .int_out   (int_out),
  .int_oe_n  (int_oe_n),
  .deselected(deselected)
);
`default_nettype wire

/* verif/brtc_host.sv */
`timescale 1ns/100ps
`default_nettype none
// Host on the parallel bus; every level changes just after a rising edge
module brtc_host (
  input  wire logic               clock,
  input  wire logic         [7:0] dq_out,
  input  wire logic               dq_oe_n,
  output brtc_pkg::brtc_bus_t     bus
);
  import brtc_pkg::*;
  initial bus = '{13'h0000, 8'h00, 1'b1, 1'b0, 1'b1, 1'b1};

  // Mode picks which edge opens and closes the write: 0 strobe, 1 low select, 2 high select
  task wr(input logic [12:0] a, input logic [7:0] d, input logic [1:0] m);
    @(posedge clock);
    bus.addr <= a;
    bus.wdata <= d;
    bus.gate_n <= 1'b1;
    bus.strobe_n <= (m == 2'd0);
    bus.select_low_active_n <= (m == 2'd1);
    bus.select_high_active <= (m != 2'd2);
    @(posedge clock);
    bus.strobe_n <= 1'b0;
    bus.select_low_active_n <= 1'b0;
    bus.select_high_active <= 1'b1;
    repeat (2) @(posedge clock);
    if (m == 2'd0) bus.strobe_n <= 1'b1;
    if (m == 2'd1) bus.select_low_active_n <= 1'b1;
    if (m == 2'd2) bus.select_high_active <= 1'b0;
    @(posedge clock);
    // Address held until both selects are gone; released data shows its inverse
    bus.strobe_n <= 1'b1;
    bus.select_low_active_n <= 1'b1;
    bus.select_high_active <= 1'b0;
    bus.wdata <= ~d;
    @(posedge clock);
  endtask

  // Read returns the output enable above the data byte
  task rd(input logic [12:0] a, output logic [8:0] q);
    @(posedge clock);
    bus.addr <= a;
    bus.wdata <= ~bus.wdata;
    bus.strobe_n <= 1'b1;
    bus.select_low_active_n <= 1'b0;
    bus.select_high_active <= 1'b1;
    bus.gate_n <= 1'b0;
    repeat (3) @(posedge clock);
    q = {dq_oe_n, dq_out};
    bus.select_low_active_n <= 1'b1;
    bus.select_high_active <= 1'b0;
    bus.gate_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* verif/test_brtc_top.sv */
`timescale 1ns/100ps
`default_nettype none
module test_brtc_top;
  import brtc_pkg::*;
  localparam int SEC = 256;
  logic            clock, rstn, power_fail;
  logic            osc_tick = 1'b0;
  logic      [1:0] tick_div = 2'h0;
  brtc_bus_t       bus;
  logic      [7:0] dq_out, frozen, d;
  logic            dq_oe_n, int_out, int_oe_n, deselected;
  logic      [8:0] q;
  int              fail_count, n_compared;
  int              cycles = 0;

  brtc_top #(.OSC_HZ(64), .DESEL_US(10), .REC_CYCLES(20)) i_brtc_top (.clock(clock),
    .rstn(rstn), .osc_tick(osc_tick), .power_fail(power_fail), .bus(bus), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .int_out(int_out), .int_oe_n(int_oe_n), .deselected(deselected));
  brtc_host i_brtc_host (.clock(clock), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .bus(bus));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Oscillator pulse every 4 clocks, so one second is 256 clocks; the run cap catches hangs
  always @(posedge clock) begin
    tick_div <= tick_div + 2'd1;
    osc_tick <= (tick_div == 2'h3);
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task check(input string n, input logic [8:0] e, input logic [8:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task rdc(input logic [12:0] a, input logic [7:0] e, input string n);
    i_brtc_host.rd(a, q);
    check(n, {1'b0, e}, q);
  endtask

  task wr(input logic [12:0] a, input logic [7:0] v, input logic [1:0] m);
    i_brtc_host.wr(a, v, m);
  endtask

  task wait_desel(input logic want);
    for (int i = 0; i < 2000; i++) if (deselected !== want) @(posedge clock);
  endtask

  task tally_and_finish;
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Load the seconds byte, test and spare bits kept zero, between two control writes
  task load_sec(input logic [7:0] s);
    wr(13'h1FF8, 8'h80, 2'd0);
    wr(13'h1FF9, s, 2'd1);
    wr(13'h1FF8, 8'h00, 2'd2);
  endtask

  initial begin
    {rstn, power_fail, fail_count, n_compared} = '0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rdc(13'h1FF8, 8'h00, "control");
    rdc(13'h1FF9, 8'h00, "seconds");
    for (int m = 0; m < 3; m++) wr(13'h0100 + 13'(m), 8'hA5 ^ 8'(m), 2'(m));
    wr(13'h1FF7, 8'h3C, 2'd0);
    for (int m = 0; m < 3; m++) rdc(13'h0100 + 13'(m), 8'hA5 ^ 8'(m), "storage");
    // Two seconds before the century ends, with the load bit held around the time bytes
    wr(13'h1FF8, 8'h80, 2'd0);
    wr(13'h1FF9, 8'h58, 2'd0);
    wr(13'h1FFA, 8'h59, 2'd1);
    wr(13'h1FFB, 8'h23, 2'd2);
    wr(13'h1FFC, 8'h07, 2'd0);
    wr(13'h1FFD, 8'h31, 2'd1);
    wr(13'h1FFE, 8'h12, 2'd2);
    wr(13'h1FFF, 8'h99, 2'd0);
    wr(13'h1FF8, 8'h00, 2'd0);
    repeat (SEC * 5 / 2) @(posedge clock);
    wr(13'h1FF8, 8'h40, 2'd0);
    rdc(13'h1FFA, 8'h00, "minutes");
    rdc(13'h1FFB, 8'h00, "hours");
    rdc(13'h1FFC, 8'h01, "weekday");
    rdc(13'h1FFD, 8'h01, "date");
    rdc(13'h1FFE, 8'h01, "month");
    rdc(13'h1FFF, 8'h00, "year");
    i_brtc_host.rd(13'h1FF9, q);
    frozen = q[7:0];
    check("seconds after load", 9'h000, {q[8], q[7:0] & 8'hFE});
    repeat (SEC * 2) @(posedge clock);
    rdc(13'h1FF9, frozen, "frozen seconds");
    wr(13'h1FF8, 8'h00, 2'd0);
    repeat (SEC * 3 / 2) @(posedge clock);
    i_brtc_host.rd(13'h1FF9, q);
    d = q[7:0] - frozen;
    check("seconds resumed", 9'h001, {q[8], 7'h00, d > 8'h02 && d < 8'h06});
    // Stop the oscillator, then restart it by writing one and then zero
    load_sec(8'h90);
    repeat (SEC * 2) @(posedge clock);
    rdc(13'h1FF9, 8'h90, "halted seconds");
    load_sec(8'h10);
    repeat (SEC * 5 / 2) @(posedge clock);
    i_brtc_host.rd(13'h1FF9, q);
    check("restarted seconds", 9'h012, {q[8], q[7:0] & 8'hFE});
    // Frequency test: seconds bit 0 flips once in 32 oscillator pulses, 128 clocks here
    wr(13'h1FFC, 8'h41, 2'd1);
    i_brtc_host.rd(13'h1FF9, q);
    frozen = q[7:0];
    repeat (124) @(posedge clock);
    i_brtc_host.rd(13'h1FF9, q);
    check("probe toggle", 9'h001, {q[8], 7'h00, q[0] ^ frozen[0]});
    wr(13'h1FFC, 8'h01, 2'd2);
    // Power loss: writes during and just after it must not land
    power_fail <= 1'b1;
    repeat (3) @(posedge clock);
    check("interrupt", 9'h000, {8'h00, int_oe_n});
    wait_desel(1'b1);
    i_brtc_host.rd(13'h0100, q);
    check("deselected read", 9'h100, {q[8], 8'h00});
    wr(13'h0100, 8'h00, 2'd0);
    power_fail <= 1'b0;
    wr(13'h0101, 8'hEE, 2'd1);
    wait_desel(1'b0);
    check("interrupt released", 9'h001, {8'h00, int_oe_n});
    rdc(13'h0100, 8'hA5, "kept byte");
    rdc(13'h0101, 8'hA4, "recovery byte");
    rdc(13'h1FF7, 8'h3C, "other byte");
    tally_and_finish();
  end
endmodule
`default_nettype wire
